// *** logic/icc_defs.svh ***
// Register offsets, field positions, reset values and flag layout of the
// interrupt-clear and control block. Included by the package and the testbench.
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ICC_OFF_RX_DONE_CLR 8'h58
`define ICC_OFF_ACTIVITY_CLR 8'h5c
`define ICC_OFF_STOP_CLR 8'h60
`define ICC_OFF_START_CLR 8'h64
`define ICC_OFF_BCAST_CLR 8'h68
`define ICC_OFF_CONTROL 8'h6c
`define ICC_OFF_FLAG_STATUS 8'h90
`define ICC_OFF_FLAG_MASK 8'h94

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ICC_CTL_ENABLE_BIT 0
`define ICC_CTL_ABORT_BIT 1
`define ICC_CTL_TXBLOCK_BIT 2

// ----------------------------------------
// Flag positions in the raw status word
// ----------------------------------------
`define ICC_FLAG_LSB 6
`define ICC_FLAG_MSB 11
`define ICC_FLAG_NUM 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ICC_RST_WORD 32'h0000_0000
`define ICC_RST_FLAGS 6'h00

`endif

// *** logic/icc_pkg.sv ***
// Types shared by the interrupt-clear and control block.
// Assumes icc_defs.svh is on the include path.
`include "icc_defs.svh"

package icc_pkg;

    // Flag slots, offset by ICC_FLAG_LSB in the raw status word
    typedef enum logic [2:0] {
        FLG_TX_ABORT = 3'b000,
        FLG_RX_DONE = 3'b001,
        FLG_ACTIVITY = 3'b010,
        FLG_STOP = 3'b011,
        FLG_START = 3'b100,
        FLG_BCAST = 3'b101
    } icc_flag_t;

    // Master-mode abort sequence
    typedef enum logic [1:0] {
        AB_IDLE = 2'b00,
        AB_WAIT_XFER = 2'b01,
        AB_STOP = 2'b10,
        AB_FLUSH = 2'b11
    } icc_abort_state_t;

endpackage : icc_pkg

// *** logic/icc_flag_if.sv ***
// Carrier between the control block and its sticky flag bank.
// Set and clear are single-cycle terms on the same clock, except activity's set and auto clear, which are levels.
interface icc_flag_if #(
    parameter int NUM = 6
);
    logic [NUM-1:0] set;
    logic [NUM-1:0] clr;
    logic [NUM-1:0] flags;

    modport bank (
        input set,
        input clr,
        output flags
    );

    modport user (
        output set,
        output clr,
        input flags
    );
endinterface : icc_flag_if

// *** logic/icc_flags.sv ***
// Bank of sticky interrupt flags.
// Assumes set and clear come from logic on pclk; set wins over clear.
module icc_flags
    import icc_pkg::*;
#(
    parameter int NUM = 6
)
(
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // Flag carrier
    icc_flag_if.bank fl
);

    logic [NUM-1:0] flags_q;

    // ----------------------------------------
    // One sticky bit per flag
    // ----------------------------------------
    for (genvar i = 0; i < NUM; i++)
    begin : g_flag
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                flags_q[i] <= 1'b0;
            else if (pce)
                flags_q[i] <= fl.set[i] | (flags_q[i] & ~fl.clr[i]);
        end
    end

    assign fl.flags = flags_q;

endmodule : icc_flags

// *** logic/icc_ctrl.sv ***
// Interrupt-clear registers and main control of the two-wire controller.
// Assumes an APB master on pclk and the bus engine, queues and state
// machines on the same clock, so their status inputs need no synchroniser.
module icc_ctrl
    import icc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events and state from the bus engine
    input wire logic rx_done_evt,
    input wire logic stop_seen_evt,
    input wire logic start_seen_evt,
    input wire logic bcast_call_evt,
    input wire logic ctl_active,
    input wire logic bus_busy,
    input wire logic xfer_busy,
    input wire logic rx_busy,
    input wire logic stop_done,
    // Controls to the bus engine and queues
    output logic module_enable,
    output logic txq_flush,
    output logic rxq_flush,
    output logic halt_after_byte,
    output logic rx_nack,
    output logic stop_req,
    output logic cmd_block,
    output logic activity_status,
    // Interrupt
    output logic irq
);

    localparam int NF = `ICC_FLAG_NUM;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic en_q;
    logic txblk_q;
    logic [NF-1:0] mask_q;
    icc_abort_state_t ab_q;
    icc_abort_state_t ab_d;
    logic txq_flush_q;
    logic rxq_flush_q;
    logic halt_q;
    logic rx_nack_q;
    logic stop_req_q;
    logic cmd_block_q;
    logic act_ind_q;
    logic irq_q;
    logic [31:0] rd_data;

    icc_flag_if #(.NUM(NF)) fl ();

    icc_flags #(
        .NUM(NF)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .fl(fl.bank)
    );

    // ----------------------------------------
    // APB phases and address decode
    // ----------------------------------------
    // One wait state: read data is captured in the first access cycle and
    // side effects land on the completing edge, so a read-clear and a
    // write take effect exactly once per transfer.
    wire logic acc_first = pce & psel & penable & ~pready_q;
    wire logic acc_done = pce & psel & penable & pready_q;
    wire logic wr_done = acc_done & pwrite;
    wire logic rd_done = acc_done & ~pwrite;

    wire logic hit_rdc = paddr == ADDR_W'(`ICC_OFF_RX_DONE_CLR);
    wire logic hit_aic = paddr == ADDR_W'(`ICC_OFF_ACTIVITY_CLR);
    wire logic hit_spc = paddr == ADDR_W'(`ICC_OFF_STOP_CLR);
    wire logic hit_stc = paddr == ADDR_W'(`ICC_OFF_START_CLR);
    wire logic hit_bcc = paddr == ADDR_W'(`ICC_OFF_BCAST_CLR);
    wire logic hit_ctl = paddr == ADDR_W'(`ICC_OFF_CONTROL);
    wire logic hit_sts = paddr == ADDR_W'(`ICC_OFF_FLAG_STATUS);
    wire logic hit_msk = paddr == ADDR_W'(`ICC_OFF_FLAG_MASK);
    wire logic mapped = hit_rdc | hit_aic | hit_spc | hit_stc | hit_bcc
                      | hit_ctl | hit_sts | hit_msk;

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    wire logic [NF-1:0] flg = fl.flags;
    wire logic ab_busy = ab_q != AB_IDLE;

    always_comb
    begin
        rd_data = `ICC_RST_WORD;
        if (hit_rdc)
            rd_data[0] = flg[FLG_RX_DONE];
        else if (hit_aic)
            rd_data[0] = flg[FLG_ACTIVITY];
        else if (hit_spc)
            rd_data[0] = flg[FLG_STOP];
        else if (hit_stc)
            rd_data[0] = flg[FLG_START];
        else if (hit_bcc)
            rd_data[0] = flg[FLG_BCAST];
        else if (hit_ctl)
        begin
            rd_data[`ICC_CTL_ENABLE_BIT] = en_q;
            rd_data[`ICC_CTL_ABORT_BIT] = ab_busy;
            rd_data[`ICC_CTL_TXBLOCK_BIT] = txblk_q;
        end
        else if (hit_sts)
            rd_data[`ICC_FLAG_MSB:`ICC_FLAG_LSB] = flg;
        else if (hit_msk)
            rd_data[`ICC_FLAG_MSB:`ICC_FLAG_LSB] = mask_q;
    end // Unlisted bits stay zero

    // ----------------------------------------
    // Flag set and clear terms
    // ----------------------------------------
    wire logic [NF-1:0] w1c = (wr_done & hit_sts)
                            ? pwdata[`ICC_FLAG_MSB:`ICC_FLAG_LSB] : '0;
    wire logic ab_fin = ab_q == AB_FLUSH;
    wire logic act_rd_clr = rd_done & hit_aic & ~ctl_active;
    wire logic act_auto_clr = ~en_q & ~ctl_active & ~bus_busy;

    // Activity is set as a level, so it stays set while still active
    assign fl.set[FLG_TX_ABORT] = ab_fin;
    assign fl.set[FLG_RX_DONE] = rx_done_evt;
    assign fl.set[FLG_ACTIVITY] = ctl_active;
    assign fl.set[FLG_STOP] = stop_seen_evt;
    assign fl.set[FLG_START] = start_seen_evt;
    assign fl.set[FLG_BCAST] = bcast_call_evt;

    assign fl.clr[FLG_TX_ABORT] = w1c[FLG_TX_ABORT];
    assign fl.clr[FLG_RX_DONE] = (rd_done & hit_rdc) | w1c[FLG_RX_DONE];
    assign fl.clr[FLG_ACTIVITY] = act_rd_clr | act_auto_clr
                                | (w1c[FLG_ACTIVITY] & ~ctl_active);
    assign fl.clr[FLG_STOP] = (rd_done & hit_spc) | w1c[FLG_STOP];
    assign fl.clr[FLG_START] = (rd_done & hit_stc) | w1c[FLG_START];
    assign fl.clr[FLG_BCAST] = (rd_done & hit_bcc) | w1c[FLG_BCAST];

    // ----------------------------------------
    // Control register writes
    // ----------------------------------------
    wire logic ctl_wr = wr_done & hit_ctl;
    // Abort is taken only from an enabled controller with no abort running
    wire logic ab_take = ctl_wr & pwdata[`ICC_CTL_ABORT_BIT]
                       & en_q & ~ab_busy;

    // ----------------------------------------
    // Abort sequence
    // ----------------------------------------
    always_comb
    begin
        ab_d = ab_q;
        case (ab_q)
            AB_IDLE:
            begin
                if (ab_take)
                    ab_d = AB_WAIT_XFER;
            end
            AB_WAIT_XFER:
            begin
                if (!xfer_busy)
                    ab_d = AB_STOP;
            end
            AB_STOP:
            begin
                if (stop_done)
                    ab_d = AB_FLUSH;
            end
            AB_FLUSH:
            begin
                ab_d = AB_IDLE;
            end
            default:
            begin
                ab_d = AB_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Engine controls
    // ----------------------------------------
    // While disabled the queues are held flushed, but only once the byte
    // in flight has left the shifter, so the current transfer completes.
    wire logic dis_idle = ~en_q & ~xfer_busy;
    wire logic txq_flush_d = dis_idle | ab_fin;
    wire logic rxq_flush_d = dis_idle;
    wire logic halt_d = ~en_q & xfer_busy;
    wire logic rx_nack_d = ~en_q & rx_busy;
    wire logic stop_req_d = ab_q == AB_STOP;
    // Blocking covers queued commands too, and an abort must not let
    // fresh queue data start a new transfer.
    wire logic cmd_block_d = txblk_q | ab_busy | ~en_q;
    wire logic irq_d = |(flg & mask_q);

    // ----------------------------------------
    // APB response registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `ICC_RST_WORD;
        end
        else if (pce)
        begin
            pready_q <= acc_first;
            pslverr_q <= acc_first & ~mapped;
            if (acc_first && !pwrite)
                prdata_q <= rd_data;
        end
    end

    // ----------------------------------------
    // Software-visible control state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 1'b0;
            txblk_q <= 1'b0;
            mask_q <= `ICC_RST_FLAGS;
            ab_q <= AB_IDLE;
        end
        else if (pce)
        begin
            if (ctl_wr)
            begin
                en_q <= pwdata[`ICC_CTL_ENABLE_BIT];
                txblk_q <= pwdata[`ICC_CTL_TXBLOCK_BIT];
            end
            if (wr_done && hit_msk)
                mask_q <= pwdata[`ICC_FLAG_MSB:`ICC_FLAG_LSB];
            ab_q <= ab_d;
        end
    end

    // ----------------------------------------
    // Registered outputs to the engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txq_flush_q <= 1'b1;
            rxq_flush_q <= 1'b1;
            halt_q <= 1'b0;
            rx_nack_q <= 1'b0;
            stop_req_q <= 1'b0;
            cmd_block_q <= 1'b1;
        end
        else if (pce)
        begin
            txq_flush_q <= txq_flush_d;
            rxq_flush_q <= rxq_flush_d;
            halt_q <= halt_d;
            rx_nack_q <= rx_nack_d;
            stop_req_q <= stop_req_d;
            cmd_block_q <= cmd_block_d;
        end
    end

    // ----------------------------------------
    // Activity indication and interrupt
    // ----------------------------------------
    // Cleared only when disabled and the engine is back at idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_ind_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (pce)
        begin
            if (en_q || ctl_active)
                act_ind_q <= 1'b1;
            else
                act_ind_q <= 1'b0;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------
    // Output ports
    // ----------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign module_enable = en_q;
    assign txq_flush = txq_flush_q;
    assign rxq_flush = rxq_flush_q;
    assign halt_after_byte = halt_q;
    assign rx_nack = rx_nack_q;
    assign stop_req = stop_req_q;
    assign cmd_block = cmd_block_q;
    assign activity_status = act_ind_q;
    assign irq = irq_q;

endmodule : icc_ctrl

// *** tb/icc_ctrl_assertions.sv ***
// Concurrent checks on the ports of the interrupt-clear and control block.
// Assumes one clock domain and the registered outputs described in the hand-over.
module icc_ctrl_assertions
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB response
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Engine status
    input wire logic xfer_busy,
    input wire logic rx_busy,
    input wire logic ctl_active,
    input wire logic stop_done,
    // Controls and interrupt
    input wire logic module_enable,
    input wire logic txq_flush,
    input wire logic rxq_flush,
    input wire logic halt_after_byte,
    input wire logic rx_nack,
    input wire logic stop_req,
    input wire logic cmd_block,
    input wire logic activity_status,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    apb_answer_a: assert property (psel && $rose(penable) |=> pready ##1 !pready)
        else $error("pready not a single pulse after the access phase");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    flush_idle_a: assert property ((!module_enable && !xfer_busy)[*2]
        |-> txq_flush && rxq_flush)
        else $error("queues not flushed while disabled and idle");
    run_noflush_a: assert property (module_enable[*2] |-> !rxq_flush)
        else $error("receive queue flushed while enabled");
    halt_byte_a: assert property ((!module_enable && xfer_busy)[*2] |-> halt_after_byte)
        else $error("no halt request when disabled mid transfer");
    rx_nack_a: assert property ((!module_enable && rx_busy)[*2] |-> rx_nack)
        else $error("no nack request when disabled mid byte");
    hold_busy_a: assert property (activity_status && ctl_active |=> activity_status)
        else $error("activity status fell while controller active");
    block_off_a: assert property ((!module_enable)[*2] |-> cmd_block)
        else $error("commands not blocked while disabled");
    stop_wait_a: assert property ($rose(stop_req) |-> $past(xfer_busy) == 1'b0)
        else $error("stop requested during a transfer");
    abort_flush_a: assert property (stop_req && stop_done |-> ##[1:2] txq_flush)
        else $error("transmit queue not flushed after abort stop");

    cover property (stop_req && stop_done);
    cover property ($rose(irq));
    cover property (halt_after_byte && rx_nack);
endmodule : icc_ctrl_assertions

bind icc_ctrl icc_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .xfer_busy(xfer_busy),
    .rx_busy(rx_busy), .ctl_active(ctl_active), .stop_done(stop_done),
    .module_enable(module_enable), .txq_flush(txq_flush), .rxq_flush(rxq_flush),
    .halt_after_byte(halt_after_byte), .rx_nack(rx_nack), .stop_req(stop_req),
    .cmd_block(cmd_block), .activity_status(activity_status), .irq(irq));

// *** tb/icc_engine_model.sv ***
// Stand-in for the bus engine's answer to a STOP request.
// Assumes stop_req is a registered level on pclk; delay is set by the bench.
module icc_engine_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // STOP handshake
    input wire logic stop_req,
    input wire logic [3:0] stop_dly,
    output logic stop_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;

    // Counts only while a request is live, so a stale pulse cannot end a later abort
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            stop_done <= 1'b0;
        end
        else if (stop_req && !stop_done)
        begin
            cnt_q <= cnt_q + 4'h1;
            stop_done <= (cnt_q == stop_dly);
        end
        else
        begin
            cnt_q <= 4'h0;
            stop_done <= 1'b0;
        end
    end
endmodule : icc_engine_model

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt-clear and control block.
// Assumes the design, the engine model and the checker are compiled first.
`include "icc_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic ctl_active, bus_busy, xfer_busy, rx_busy, stop_done, stop_req;
    logic mod_en, txq_flush, rxq_flush, halt_byte, rx_nack, cmd_block, act_st;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] evt, stop_dly;
    int mismatches, total_checks, cycles;
    logic [7:0] clr_off [4] = '{`ICC_OFF_RX_DONE_CLR, `ICC_OFF_STOP_CLR, `ICC_OFF_START_CLR,
        `ICC_OFF_BCAST_CLR};
    int fbit [4] = '{7, 9, 10, 11};

    icc_ctrl uut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_done_evt(evt[0]), .stop_seen_evt(evt[1]),
        .start_seen_evt(evt[2]), .bcast_call_evt(evt[3]), .ctl_active(ctl_active),
        .bus_busy(bus_busy), .xfer_busy(xfer_busy), .rx_busy(rx_busy), .stop_done(stop_done),
        .module_enable(mod_en), .txq_flush(txq_flush), .rxq_flush(rxq_flush),
        .halt_after_byte(halt_byte), .rx_nack(rx_nack), .stop_req(stop_req),
        .cmd_block(cmd_block), .activity_status(act_st), .irq(irq));
    icc_engine_model u_eng (.pclk(pclk), .presetn(presetn), .stop_req(stop_req),
        .stop_dly(stop_dly), .stop_done(stop_done));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task close_out;
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the bench timeout ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, e);
    endtask : rdc

    task tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick

    task pulse(input int i);
        @(posedge pclk);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt <= 4'h0;
    endtask : pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        logic [7:0] offs [8] = '{8'h58, 8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h90, 8'h94};
        foreach (offs[i])
        begin
            rdc(offs[i], 32'h0000_0000, "reset value");
            chk("no error", {31'h0, err}, 32'h0000_0000);
        end
        apb(1'b0, 8'h70, 32'h0000_0000);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    endtask : t_reset

    task t_flags;
        apb(1'b1, `ICC_OFF_FLAG_MASK, 32'h0000_0fc0);
        for (int i = 0; i < 4; i++)
        begin
            pulse(i);
            tick(2);
            chk("irq set", {31'h0, irq}, 32'h0000_0001);
            rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0001 << fbit[i], "flag set");
            rdc(clr_off[i], 32'h0000_0001, "clear read");
            rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0000, "flag cleared");
            chk("irq clear", {31'h0, irq}, 32'h0000_0000);
        end
        apb(1'b1, `ICC_OFF_FLAG_MASK, 32'h0000_0000);
        pulse(0);
        tick(2);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        rdc(`ICC_OFF_RX_DONE_CLR, 32'h0000_0001, "masked clear");
        apb(1'b1, `ICC_OFF_FLAG_MASK, 32'h0000_0fc0);
    endtask : t_flags

    task t_ctrl;
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0003);
        rdc(`ICC_OFF_CONTROL, 32'h0000_0001, "abort ignored");
        chk("enable out", {31'h0, mod_en}, 32'h0000_0001);
        apb(1'b1, `ICC_OFF_CONTROL, 32'hffff_fffd);
        rdc(`ICC_OFF_CONTROL, 32'h0000_0005, "reserved bits");
        chk("block set", {31'h0, cmd_block}, 32'h0000_0001);
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0001);
        tick(2);
        chk("block clear", {31'h0, cmd_block}, 32'h0000_0000);
    endtask : t_ctrl

    task t_act;
        @(posedge pclk);
        ctl_active <= 1'b1;
        tick(2);
        rdc(`ICC_OFF_ACTIVITY_CLR, 32'h0000_0001, "activity read");
        rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0100, "activity kept");
        ctl_active <= 1'b0;
        rdc(`ICC_OFF_ACTIVITY_CLR, 32'h0000_0001, "activity read");
        rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0000, "activity cleared");
        @(posedge pclk);
        ctl_active <= 1'b1;
        bus_busy <= 1'b1;
        // Clean shutdown: clear enable, then wait for idle before re-enabling
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0000);
        tick(2);
        chk("status held", {31'h0, act_st}, 32'h0000_0001);
        @(posedge pclk);
        ctl_active <= 1'b0;
        tick(3);
        rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0100, "bus busy keeps flag");
        bus_busy <= 1'b0;
        tick(3);
        rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0000, "auto clear");
        chk("status idle", {31'h0, act_st}, 32'h0000_0000);
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0001);
    endtask : t_act

    task t_abort(input logic [3:0] dly);
        stop_dly <= dly;
        @(posedge pclk);
        xfer_busy <= 1'b1;
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0003);
        rdc(`ICC_OFF_CONTROL, 32'h0000_0003, "abort running");
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0001);
        rdc(`ICC_OFF_CONTROL, 32'h0000_0003, "abort sticky");
        chk("no stop mid transfer", {31'h0, stop_req}, 32'h0000_0000);
        xfer_busy <= 1'b0;
        while (stop_done !== 1'b1)
            tick(1);
        chk("stop issued", {31'h0, stop_req}, 32'h0000_0001);
        tick(4);
        rdc(`ICC_OFF_FLAG_STATUS, 32'h0000_0040, "abort flag");
        chk("abort irq", {31'h0, irq}, 32'h0000_0001);
        rdc(`ICC_OFF_CONTROL, 32'h0000_0001, "abort done");
        apb(1'b1, `ICC_OFF_FLAG_STATUS, 32'h0000_0040);
        tick(2);
        chk("abort irq clear", {31'h0, irq}, 32'h0000_0000);
    endtask : t_abort

    task t_dis;
        @(posedge pclk);
        xfer_busy <= 1'b1;
        rx_busy <= 1'b1;
        apb(1'b1, `ICC_OFF_CONTROL, 32'h0000_0000);
        tick(2);
        chk("halt after byte", {31'h0, halt_byte}, 32'h0000_0001);
        chk("rx nack", {31'h0, rx_nack}, 32'h0000_0001);
        chk("tx kept", {31'h0, txq_flush}, 32'h0000_0000);
        chk("enable off", {31'h0, mod_en}, 32'h0000_0000);
        @(posedge pclk);
        xfer_busy <= 1'b0;
        rx_busy <= 1'b0;
        tick(3);
        chk("flushes", {30'h0, txq_flush, rxq_flush}, 32'h0000_0003);
        chk("blocked", {31'h0, cmd_block}, 32'h0000_0001);
    endtask : t_dis

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, ctl_active, bus_busy, xfer_busy, rx_busy} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        evt = 4'h0;
        stop_dly = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flags();
        t_ctrl();
        t_act();
        t_abort(4'h0);
        t_abort(4'h6);
        t_dis();
        close_out();
    end
endmodule : testbench
